// ==== adcstr_pkg.sv ====
// adcstr_pkg: register map, field layout and mode codes for the
// converter timing and repeat-control block.
// assumes byte-wide register port with 16-bit addresses.
`default_nettype none
package adcstr_pkg;
    localparam logic [15:0] ADCSTR_OFS_RPT_CNT = 16'h1D19;
    localparam logic [15:0] ADCSTR_OFS_RPT_THR = 16'h1D1A;
    localparam logic [15:0] ADCSTR_OFS_NEG_SEL = 16'h1D20;
    localparam logic [15:0] ADCSTR_OFS_ACQ_LO = 16'h1D21;
    localparam logic [15:0] ADCSTR_OFS_ACQ_HI = 16'h1D22;
    localparam logic [15:0] ADCSTR_OFS_CAP = 16'h1D23;
    localparam logic [15:0] ADCSTR_OFS_PRE_LO = 16'h1D24;
    localparam logic [15:0] ADCSTR_OFS_PRE_HI = 16'h1D25;
    localparam logic [15:0] ADCSTR_OFS_INT_STAT = 16'h1D30;
    localparam logic [15:0] ADCSTR_OFS_INT_MASK = 16'h1D31;
    localparam int ADCSTR_TIME_W = 13;
    localparam int ADCSTR_HI_W = 5;
    localparam int ADCSTR_CAP_W = 5;
    localparam int ADCSTR_NEG_W = 6;
    localparam logic [13:0] ADCSTR_ACQ_DEFAULT_LEN = 14'h2000;
    localparam logic [7:0] ADCSTR_RESET_BYTE = 8'h00;
    localparam logic [12:0] ADCSTR_RESET_TIME = 13'h0000;
    localparam int ADCSTR_SYNC_STAGES = 2;
    // conversion clock source codes
    localparam logic [1:0] ADCSTR_CS_RC = 2'h3;
    // computation modes
    localparam logic [2:0] ADCSTR_MD_AVG = 3'h2;
    localparam logic [2:0] ADCSTR_MD_BURST = 3'h3;
    localparam logic [2:0] ADCSTR_MD_LPF = 3'h4;
    // interrupt status bits
    localparam int ADCSTR_IRQ_CHECK = 0;
    localparam int ADCSTR_IRQ_DONE = 1;
    typedef enum {ADCSTR_IDLE, ADCSTR_PRE, ADCSTR_ACQ, ADCSTR_CONV} adcstr_state_t;
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } adcstr_bus_t;
    typedef struct packed {
        logic precharge;
        logic acquire;
        logic convert_go;
        logic [4:0] cap_pf;
        logic [5:0] neg_sel;
        logic neg_valid;
    } adcstr_analog_t;
endpackage
`default_nettype wire

// ==== adcstr_sync.sv ====
// adcstr_sync: two-flop synchroniser for one level.
// assumes input is asynchronous to clk_sys_i.
`timescale 1ns/1ps
`default_nettype none
module adcstr_sync (
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic async_i,
    output logic sync_o
);
    logic meta_r;
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            meta_r <= 1'b0;
            sync_o <= 1'b0;
        end else begin
            meta_r <= async_i;
            sync_o <= meta_r;
        end
    end
endmodule
`default_nettype wire

// ==== adcstr_ctrl.sv ====
// adcstr_ctrl: conversion phase timer, extra load, negative input
// select and repeat counter with threshold-check event.
// assumes rc_tick_i is a raw pin-side oscillator level; trigger is local.
//
// How it works
// - a nonzero precharge count n gives n timing clocks of precharge, zero skips it.
// - phases count system clocks unless the rc oscillator is the source, then its rising edges.
// - a nonzero sample window n gives n timing clocks of acquisition.
// - with both window and precharge zero, acquisition is skipped.
// - window zero with precharge nonzero gives 8192 clocks of acquisition.
// - extra load output equals the 5-bit field in pF, zero adds none.
// - an 8-bit repeat threshold register sets triggers per check.
// - an 8-bit counter counts triggers and fires a check when it reaches the threshold.
// - counting and checking only run in filter, burst average and average modes.
// - the repeat counter is software read and write and resets to zero.
// - precharge length is reached as a high byte of bits 12:8 and a low byte.
// - sample window is reached as a high byte of bits 12:8 and a low byte.
// - negative codes 6,5,3,1 select port A pins, codes 4,2,0 connect nothing.
// - the negative select is a 6-bit software field reset to zero.
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module adcstr_ctrl (
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire adcstr_pkg::adcstr_bus_t bus_i,
    output logic [7:0] rdata_o,
    input wire logic [1:0] clk_src_i,
    input wire logic [2:0] comp_mode_i,
    input wire logic rc_tick_i,
    input wire logic trigger_i,
    input wire logic conv_done_i,
    output adcstr_pkg::adcstr_analog_t analog_o,
    output logic busy_o,
    output logic check_o,
    output logic irq_o
);
    import adcstr_pkg::*;

    logic [7:0] cnt_r;
    logic [7:0] thr_r;
    logic [12:0] pre_r;
    logic [12:0] acq_r;
    logic [4:0] cap_r;
    logic [5:0] neg_r;
    logic [1:0] stat_r;
    logic [1:0] mask_r;
    logic rc_sync;
    logic rc_prev_r;
    logic tick;
    logic mode_ok;
    logic [13:0] left_r;
    adcstr_state_t st_r;
    logic wr_cnt, wr_thr;
    logic rd_stat;
    logic [1:0] ev;

    adcstr_sync u_rc_sync (
        .clk_sys_i(clk_sys_i),
        .srst_i(srst_i),
        .async_i(rc_tick_i),
        .sync_o(rc_sync)
    );

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            rc_prev_r <= 1'b0;
        end else begin
            rc_prev_r <= rc_sync;
        end
    end

    assign tick = (clk_src_i == ADCSTR_CS_RC) ? (rc_sync & ~rc_prev_r) : 1'b1;

    assign mode_ok = (comp_mode_i == ADCSTR_MD_LPF) || (comp_mode_i == ADCSTR_MD_BURST)
        || (comp_mode_i == ADCSTR_MD_AVG);

    assign wr_cnt = bus_i.wr && bus_i.addr == ADCSTR_OFS_RPT_CNT;
    assign wr_thr = bus_i.wr && bus_i.addr == ADCSTR_OFS_RPT_THR;
    assign rd_stat = bus_i.rd && bus_i.addr == ADCSTR_OFS_INT_STAT;

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            thr_r <= ADCSTR_RESET_BYTE;
        end else if (wr_thr) begin
            thr_r <= bus_i.wdata;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            pre_r <= ADCSTR_RESET_TIME;
        end else if (bus_i.wr && bus_i.addr == ADCSTR_OFS_PRE_LO) begin
            pre_r[7:0] <= bus_i.wdata;
        end else if (bus_i.wr && bus_i.addr == ADCSTR_OFS_PRE_HI) begin
            pre_r[12:8] <= bus_i.wdata[ADCSTR_HI_W-1:0];
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            acq_r <= ADCSTR_RESET_TIME;
        end else if (bus_i.wr && bus_i.addr == ADCSTR_OFS_ACQ_LO) begin
            acq_r[7:0] <= bus_i.wdata;
        end else if (bus_i.wr && bus_i.addr == ADCSTR_OFS_ACQ_HI) begin
            acq_r[12:8] <= bus_i.wdata[ADCSTR_HI_W-1:0];
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            neg_r <= '0;
            cap_r <= '0;
            mask_r <= '0;
        end else if (bus_i.wr) begin
            if (bus_i.addr == ADCSTR_OFS_NEG_SEL) begin
                neg_r <= bus_i.wdata[ADCSTR_NEG_W-1:0];
            end
            if (bus_i.addr == ADCSTR_OFS_CAP) begin
                cap_r <= bus_i.wdata[ADCSTR_CAP_W-1:0];
            end
            if (bus_i.addr == ADCSTR_OFS_INT_MASK) begin
                mask_r <= bus_i.wdata[1:0];
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            st_r <= ADCSTR_IDLE;
            left_r <= '0;
        end else begin
            unique case (st_r)
                ADCSTR_IDLE: begin
                    if (trigger_i) begin
                        if (pre_r != '0) begin
                            st_r <= ADCSTR_PRE;
                            left_r <= {1'b0, pre_r};
                        end else if (acq_r != '0) begin
                            st_r <= ADCSTR_ACQ;
                            left_r <= {1'b0, acq_r};
                        end else begin
                            st_r <= ADCSTR_CONV;
                        end
                    end
                end
                ADCSTR_PRE: begin
                    if (tick) begin
                        if (left_r == 14'h0001) begin
                            st_r <= ADCSTR_ACQ;
                            left_r <= (acq_r == '0) ? ADCSTR_ACQ_DEFAULT_LEN : {1'b0, acq_r};
                        end else begin
                            left_r <= left_r - 14'h0001;
                        end
                    end
                end
                ADCSTR_ACQ: begin
                    if (tick) begin
                        if (left_r == 14'h0001) begin
                            st_r <= ADCSTR_CONV;
                        end else begin
                            left_r <= left_r - 14'h0001;
                        end
                    end
                end
                ADCSTR_CONV: begin
                    if (conv_done_i) begin
                        st_r <= ADCSTR_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            cnt_r <= ADCSTR_RESET_BYTE;
            check_o <= 1'b0;
        end else begin
            check_o <= 1'b0;
            if (wr_cnt) begin
                cnt_r <= bus_i.wdata;
            end else if (trigger_i && mode_ok) begin
                if (cnt_r + 8'h01 >= thr_r) begin
                    check_o <= 1'b1;
                    cnt_r <= ADCSTR_RESET_BYTE;
                end else begin
                    cnt_r <= cnt_r + 8'h01;
                end
            end
        end
    end

    assign ev[ADCSTR_IRQ_CHECK] = check_o;
    assign ev[ADCSTR_IRQ_DONE] = (st_r == ADCSTR_CONV) && conv_done_i;

    // sticky status, set wins over read clear
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            stat_r <= '0;
        end else begin
            stat_r <= (rd_stat ? 2'h0 : stat_r) | ev;
        end
    end

    assign irq_o = |(stat_r & mask_r);

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            rdata_o <= 8'h00;
        end else if (bus_i.rd) begin
            unique case (bus_i.addr)
                ADCSTR_OFS_RPT_CNT: rdata_o <= cnt_r;
                ADCSTR_OFS_RPT_THR: rdata_o <= thr_r;
                ADCSTR_OFS_NEG_SEL: rdata_o <= {2'h0, neg_r};
                ADCSTR_OFS_ACQ_LO: rdata_o <= acq_r[7:0];
                ADCSTR_OFS_ACQ_HI: rdata_o <= {3'h0, acq_r[12:8]};
                ADCSTR_OFS_CAP: rdata_o <= {3'h0, cap_r};
                ADCSTR_OFS_PRE_LO: rdata_o <= pre_r[7:0];
                ADCSTR_OFS_PRE_HI: rdata_o <= {3'h0, pre_r[12:8]};
                ADCSTR_OFS_INT_STAT: rdata_o <= {6'h00, stat_r};
                ADCSTR_OFS_INT_MASK: rdata_o <= {6'h00, mask_r};
                default: rdata_o <= 8'h00;
            endcase
        end else begin
            rdata_o <= 8'h00;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            analog_o <= '0;
        end else begin
            analog_o.precharge <= (st_r == ADCSTR_PRE);
            analog_o.acquire <= (st_r == ADCSTR_ACQ);
            analog_o.convert_go <= (st_r == ADCSTR_CONV);
            analog_o.cap_pf <= cap_r;
            analog_o.neg_sel <= neg_r;
            // codes 0, 2 and 4 connect nothing
            analog_o.neg_valid <= !(neg_r == 6'h00 || neg_r == 6'h02 || neg_r == 6'h04);
        end
    end

    assign busy_o = (st_r != ADCSTR_IDLE);

    acq_default_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        (st_r == ADCSTR_PRE && tick && left_r == 14'h0001 && acq_r == '0)
        |=> (left_r == 14'h2000 && st_r == ADCSTR_ACQ))
        else $error("acquisition not 8192 after precharge");
    skip_acq_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        (st_r == ADCSTR_IDLE && trigger_i && pre_r == '0 && acq_r == '0) |=> st_r == ADCSTR_CONV)
        else $error("acquisition not skipped");
    pre_entry_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        (st_r == ADCSTR_IDLE && trigger_i && pre_r != '0) |=> (st_r == ADCSTR_PRE
        && left_r == {1'b0, $past(pre_r)}))
        else $error("precharge not started");
    phase_order_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        (st_r == ADCSTR_ACQ) |-> ($past(st_r) != ADCSTR_CONV))
        else $error("acquisition after conversion");
    mode_gate_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        (!mode_ok && !wr_cnt) |=> ($stable(cnt_r) && !check_o))
        else $error("counting outside filter modes");
    check_fire_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        (trigger_i && mode_ok && !wr_cnt && cnt_r + 8'h01 >= thr_r) |=> check_o)
        else $error("check missed");
    cnt_write_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        wr_cnt |=> cnt_r == $past(bus_i.wdata))
        else $error("counter write lost");
    rc_hold_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        (st_r == ADCSTR_ACQ && !tick) |=> $stable(left_r))
        else $error("phase advanced without timing clock");
    sys_tick_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        (st_r == ADCSTR_PRE && clk_src_i != ADCSTR_CS_RC && left_r != 14'h0001)
        |=> left_r == $past(left_r) - 14'h0001)
        else $error("precharge not counting system clocks");
    acq_entry_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        (st_r == ADCSTR_IDLE && trigger_i && pre_r == '0 && acq_r != '0)
        |=> (st_r == ADCSTR_ACQ && left_r == {1'b0, $past(acq_r)}))
        else $error("acquisition not started from window");
    cap_follow_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        analog_o.cap_pf == $past(cap_r))
        else $error("extra load not following field");
    neg_off_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        (neg_r == 6'h00 || neg_r == 6'h02 || neg_r == 6'h04) |=> !analog_o.neg_valid)
        else $error("unconnected negative code marked valid");
    neg_on_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        (neg_r == 6'h01 || neg_r == 6'h03 || neg_r == 6'h05 || neg_r == 6'h06)
        |=> analog_o.neg_valid)
        else $error("port pin negative code not connected");
    neg_write_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        (bus_i.wr && bus_i.addr == ADCSTR_OFS_NEG_SEL)
        |=> {2'h0, neg_r} == ($past(bus_i.wdata) & 8'h3F))
        else $error("negative select write lost");
    pre_high_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        (bus_i.wr && bus_i.addr == ADCSTR_OFS_PRE_HI)
        |=> {3'h0, pre_r[12:8]} == ($past(bus_i.wdata) & 8'h1F))
        else $error("precharge high byte write lost");
    acq_low_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        (bus_i.wr && bus_i.addr == ADCSTR_OFS_ACQ_LO)
        |=> acq_r[7:0] == $past(bus_i.wdata))
        else $error("window low byte write lost");
    thr_write_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        wr_thr |=> thr_r == $past(bus_i.wdata))
        else $error("threshold write lost");
    stat_set_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        check_o |=> stat_r[ADCSTR_IRQ_CHECK])
        else $error("check event not latched");
    rd_idle_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        !bus_i.rd |=> rdata_o == 8'h00)
        else $error("read data not idle");
endmodule
`default_nettype wire

// ==== adcstr_ctrl_tb.sv ====
// adcstr_ctrl_tb: self-checking bench for the converter timing and
// repeat-control block, driving its register port, trigger and clocks.
// assumes the design files and adcstr_pkg are compiled first.
`timescale 1ns/1ps
`default_nettype none
module adcstr_ctrl_tb;
    import adcstr_pkg::*;
    logic clk_sys_i = 1'b0;
    logic srst_i = 1'b1;
    adcstr_bus_t bus = '0;
    logic [7:0] rdata_o;
    logic [1:0] clk_src_i = 2'h0;
    logic [2:0] comp_mode_i = 3'h0;
    logic rc_tick_i = 1'b0;
    logic trigger_i = 1'b0;
    logic conv_done_i = 1'b0;
    adcstr_analog_t analog_o;
    logic busy_o;
    logic check_o;
    logic irq_o;
    int n_mismatch = 0;
    int n_tests = 0;
    int cyc = 0;
    int rc_div = 0;
    logic [15:0] ofs [8] = '{ADCSTR_OFS_RPT_CNT, ADCSTR_OFS_RPT_THR, ADCSTR_OFS_NEG_SEL,
        ADCSTR_OFS_ACQ_LO, ADCSTR_OFS_ACQ_HI, ADCSTR_OFS_CAP, ADCSTR_OFS_PRE_LO,
        ADCSTR_OFS_PRE_HI};
    logic [7:0] msk [8] = '{8'hFF, 8'hFF, 8'h3F, 8'hFF, 8'h1F, 8'h1F, 8'hFF, 8'h1F};

    adcstr_ctrl adcstr_ctrl_inst (
        .clk_sys_i(clk_sys_i), .srst_i(srst_i), .bus_i(bus), .rdata_o(rdata_o),
        .clk_src_i(clk_src_i), .comp_mode_i(comp_mode_i), .rc_tick_i(rc_tick_i),
        .trigger_i(trigger_i), .conv_done_i(conv_done_i), .analog_o(analog_o),
        .busy_o(busy_o), .check_o(check_o), .irq_o(irq_o)
    );

    always #2 clk_sys_i = ~clk_sys_i;

    // oscillator stand-in: one rising edge every ten system clocks
    always @(posedge clk_sys_i) begin
        rc_div <= (rc_div == 4) ? 0 : rc_div + 1;
        if (rc_div == 4) begin
            rc_tick_i <= ~rc_tick_i;
        end
    end

    task automatic results();
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    always @(posedge clk_sys_i) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            n_mismatch = n_mismatch + 1;
            results();
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests = n_tests + 1;
        if (seen !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] v);
        @(posedge clk_sys_i) begin
            bus.addr <= a;
            bus.wdata <= v;
            bus.wr <= 1'b1;
        end
        @(posedge clk_sys_i) bus.wr <= 1'b0;
    endtask

    task automatic rdchk(input logic [15:0] a, input logic [7:0] e);
        @(posedge clk_sys_i) begin
            bus.addr <= a;
            bus.rd <= 1'b1;
        end
        @(posedge clk_sys_i) bus.rd <= 1'b0;
        #1;
        check(rdata_o, e);
    endtask

    // trigger pulse; hit records a check pulse in the two following cycles
    task automatic trig(output logic hit);
        @(posedge clk_sys_i) trigger_i <= 1'b1;
        @(posedge clk_sys_i) trigger_i <= 1'b0;
        #1 hit = check_o;
        @(posedge clk_sys_i);
        #1 hit = hit | check_o;
    endtask

    task automatic pulse_done();
        @(posedge clk_sys_i) conv_done_i <= 1'b1;
        @(posedge clk_sys_i) conv_done_i <= 1'b0;
    endtask

    // one conversion; phase lengths must fall in the given ranges
    task automatic conv(input logic [12:0] pre, input logic [12:0] sample_window_length,
                        input int pl, input int ph, input int al, input int ah);
        int np;
        int na;
        int k;
        logic seen_a;
        logic bad;
        np = 0;
        na = 0;
        seen_a = 1'b0;
        bad = 1'b0;
        wr(ADCSTR_OFS_PRE_LO, pre[7:0]);
        wr(ADCSTR_OFS_PRE_HI, {3'h0, pre[12:8]});
        wr(ADCSTR_OFS_ACQ_LO, sample_window_length[7:0]);
        wr(ADCSTR_OFS_ACQ_HI, {3'h0, sample_window_length[12:8]});
        @(posedge clk_sys_i) trigger_i <= 1'b1;
        @(posedge clk_sys_i) trigger_i <= 1'b0;
        for (k = 0; k < 9000 && analog_o.convert_go !== 1'b1; k++) begin
            @(posedge clk_sys_i);
            #1;
            if (analog_o.precharge === 1'b1) begin
                np++;
                bad = bad | seen_a | analog_o.acquire;
            end
            if (analog_o.acquire === 1'b1) begin
                na++;
                seen_a = 1'b1;
            end
        end
        check(np >= pl && np <= ph, 1'b1);
        check(na >= al && na <= ah, 1'b1);
        check(bad, 1'b0);
        check(analog_o.convert_go, 1'b1);
        pulse_done();
        for (k = 0; k < 4 && busy_o !== 1'b0; k++) begin
            @(posedge clk_sys_i);
            #1;
        end
        check(busy_o, 1'b0);
    endtask

    initial begin : main
        logic hit;
        int i;
        int m;
        repeat (10) @(posedge clk_sys_i);
        srst_i <= 1'b0;
        @(posedge clk_sys_i);
        #1;
        check({analog_o, busy_o}, 16'h0000);
        check({check_o, irq_o}, 16'h0000);
        for (i = 0; i < 8; i++) begin
            rdchk(ofs[i], 8'h00);
        end
        for (i = 0; i < 8; i++) begin
            wr(ofs[i], 8'hFF);
            rdchk(ofs[i], msk[i]);
            wr(ofs[i], 8'h00);
        end
        wr(16'h1D40, 8'hFF);
        rdchk(16'h1D40, 8'h00);
        wr(ADCSTR_OFS_CAP, 8'h15);
        repeat (3) @(posedge clk_sys_i);
        #1 check(analog_o.cap_pf, 5'h15);
        wr(ADCSTR_OFS_CAP, 8'h00);
        repeat (3) @(posedge clk_sys_i);
        #1 check(analog_o.cap_pf, 5'h00);
        for (i = 0; i < 7; i++) begin
            wr(ADCSTR_OFS_NEG_SEL, i[7:0]);
            repeat (3) @(posedge clk_sys_i);
            #1 check(analog_o.neg_sel, i[5:0]);
            check(analog_o.neg_valid, i == 1 || i == 3 || i == 5 || i == 6);
        end
        conv(13'h0002, 13'h0003, 2, 2, 3, 3);
        conv(13'h0000, 13'h0004, 0, 0, 4, 4);
        conv(13'h0003, 13'h0000, 3, 3, 8192, 8192);
        conv(13'h0001, 13'h1FFF, 1, 1, 8191, 8191);
        conv(13'h0000, 13'h0000, 0, 0, 0, 0);
        @(posedge clk_sys_i) clk_src_i <= ADCSTR_CS_RC;
        conv(13'h0002, 13'h0001, 8, 30, 1, 14);
        @(posedge clk_sys_i) clk_src_i <= 2'h0;
        wr(ADCSTR_OFS_RPT_THR, 8'h03);
        for (m = 0; m < 8; m++) begin
            @(posedge clk_sys_i) comp_mode_i <= m[2:0];
            wr(ADCSTR_OFS_RPT_CNT, 8'h00);
            for (i = 1; i < 4; i++) begin
                trig(hit);
                check(hit, m >= 2 && m <= 4 && i == 3);
                rdchk(ADCSTR_OFS_RPT_CNT, (m >= 2 && m <= 4 && i < 3) ? i[7:0] : 8'h00);
            end
        end
        pulse_done();
        @(posedge clk_sys_i) comp_mode_i <= ADCSTR_MD_AVG;
        wr(ADCSTR_OFS_RPT_CNT, 8'h02);
        trig(hit);
        check(hit, 1'b1);
        rdchk(ADCSTR_OFS_INT_STAT, 8'h03);
        wr(ADCSTR_OFS_RPT_THR, 8'h00);
        wr(ADCSTR_OFS_INT_MASK, 8'h00);
        trig(hit);
        check(hit, 1'b1);
        check(irq_o, 1'b0);
        wr(ADCSTR_OFS_INT_MASK, 8'h01);
        @(posedge clk_sys_i);
        #1 check(irq_o, 1'b1);
        rdchk(ADCSTR_OFS_INT_STAT, 8'h01);
        @(posedge clk_sys_i);
        #1 check(irq_o, 1'b0);
        pulse_done();
        wr(ADCSTR_OFS_INT_MASK, 8'h02);
        @(posedge clk_sys_i);
        #1 check(irq_o, 1'b1);
        rdchk(ADCSTR_OFS_INT_STAT, 8'h02);
        @(posedge clk_sys_i);
        #1 check(irq_o, 1'b0);
        rdchk(ADCSTR_OFS_INT_MASK, 8'h02);
        results();
    end
endmodule
`default_nettype wire
